// [hdl/swa_activation_ctrl.sv]
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
// ****************************************************************
// Card-side link activation control
// ****************************************************************
// Rules this block follows or relies on
// (RULE1) Downlink rising out of deactivated state reruns the activation handshake.
// (RULE2) Subsequent activation sends no capability field in any activation frame.
// (RULE3) Front-end takes first good sync frame of a subsequent activation as success.
// (RULE4) After power-up, resume for the first sync frame within 700 us.
// (RULE5) Answer a power-mode frame within 2000 us after its end delimiter.
// (RULE6) Activated-state detection timeout is at most 100 ms from uplink high.
// (RULE7) On timeout drive uplink low and ignore the link until told otherwise.
// (RULE8) From deactivated state, resume for the first sync frame within 500 us.
// (RULE9) Front-end repeat interval should exceed card response plus resume time.
// (RULE10) In low power mode terminal keeps contact and USB interfaces off.
// (RULE11) In full power mode terminal may start other interfaces freely.
// (RULE12) Activation while contact interface is active counts as application select.
// (RULE13) Wire not tied to supply and no link support: ground it within 2 s.
// (RULE14) Terminal holds the wire low once the card lacks link support.
// (RULE15) Good power-mode frame: repeat bit 1 repeats last frame, 0 sends ready.
// (RULE16) Front-end requests at most three repeats per activation.
// (RULE17) All windows are timed by internal-clock counters with tolerance margin.
module swa_activation_ctrl #(
	parameter int RESUME_PU_CYC     = swa_pkg::RESUME_PU_CYC,
	parameter int RESUME_IDLE_CYC   = swa_pkg::RESUME_IDLE_CYC,
	parameter int PM_RESPONSE_CYC   = swa_pkg::PM_RESPONSE_CYC,
	parameter int DETECT_CYC        = swa_pkg::DETECT_CYC,
	parameter int GROUND_SETTLE_CYC = swa_pkg::GROUND_SETTLE_CYC
) (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       reset_n,
	// Register port
	input  wire logic [swa_pkg::ADDR_W-1:0] addr,
	input  wire logic [swa_pkg::DATA_W-1:0] wr_data,
	input  wire logic                       wr_strobe,
	input  wire logic                       rd_strobe,
	output logic [swa_pkg::DATA_W-1:0]      rd_data,
	output logic                            irq,
	// Shared wire pins
	input  wire logic                       downlink_voltage_signal,
	input  wire logic                       wire_tied_supply,
	output logic                            uplink_current_signal,
	output logic                            wire_gnd_out,
	output logic                            wire_gnd_oe_n,
	// Frame layer
	input  wire logic                       stack_ready,
	input  wire logic                       tx_done,
	input  wire logic                       rx_pm_done,
	input  wire logic                       rx_pm_ok,
	input  wire logic                       frame_repeat_bit,
	input  wire logic                       rx_full_power,
	output logic                            tx_sync_req,
	output logic                            tx_ready_req,
	output logic                            capability_info_field,
	output logic                            app_select_pulse
);

	localparam logic [swa_pkg::TIMER_W-1:0] LIM_PU   = RESUME_PU_CYC[swa_pkg::TIMER_W-1:0];
	localparam logic [swa_pkg::TIMER_W-1:0] LIM_IDLE = RESUME_IDLE_CYC[swa_pkg::TIMER_W-1:0];
	localparam logic [swa_pkg::TIMER_W-1:0] LIM_PM   = PM_RESPONSE_CYC[swa_pkg::TIMER_W-1:0];
	localparam logic [swa_pkg::TIMER_W-1:0] LIM_DET  = DETECT_CYC[swa_pkg::TIMER_W-1:0];
	localparam logic [swa_pkg::TIMER_W-1:0] LIM_GND  = GROUND_SETTLE_CYC[swa_pkg::TIMER_W-1:0];
	localparam logic [swa_pkg::TIMER_W-1:0] LIM_GMAX =
		swa_pkg::GROUND_MAX_CYC[swa_pkg::TIMER_W-1:0];

	// ****************************************************************
	// Pin synchronisers and downlink idle detection
	// ****************************************************************
	logic                        s1_meta;
	logic                        s1_sync;
	logic                        s1_prev;
	logic                        tie_meta;
	logic                        tie_sync;
	logic [swa_pkg::DEACT_W-1:0] low_cnt;
	logic [swa_pkg::DEACT_W-1:0] next_low_cnt;
	logic                        s1_rise;
	logic                        link_idle;

	// Two flops per pin; logic reads the second stage, plus a third downlink flop for rise detection
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s1_meta  <= 1'b0;
			s1_sync  <= 1'b0;
			s1_prev  <= 1'b0;
			tie_meta <= 1'b0;
			tie_sync <= 1'b0;
			low_cnt  <= '0;
		end else begin
			s1_meta  <= downlink_voltage_signal;
			s1_sync  <= s1_meta;
			s1_prev  <= s1_sync;
			tie_meta <= wire_tied_supply;
			tie_sync <= tie_meta;
			low_cnt  <= next_low_cnt;
		end
	end

	assign s1_rise   = s1_sync & ~s1_prev;
	assign link_idle = (low_cnt == swa_pkg::DEACT_LIM);

	// Downlink low longer than any bit's low phase means deactivated
	always_comb begin
		next_low_cnt = low_cnt;
		if (s1_sync)
			next_low_cnt = '0;
		else if (!link_idle)
			next_low_cnt = low_cnt + swa_pkg::DEACT_ONE;
	end

	// ****************************************************************
	// Timers
	// ****************************************************************
	logic                        win_load;
	logic                        win_stop;
	logic [swa_pkg::TIMER_W-1:0] win_limit;
	logic                        win_expired;
	logic [swa_pkg::TIMER_W-1:0] win_elapsed;
	logic                        gnd_load;
	logic                        gnd_stop;
	logic                        gnd_running;
	logic                        gnd_expired;
	logic [swa_pkg::TIMER_W-1:0] gnd_elapsed;

	// One timer shared by the activation windows, which never overlap
	swa_timer u_win_timer (
		.clock   (clock),
		.reset_n (reset_n),
		.load    (win_load),
		.stop    (win_stop),
		.limit   (win_limit),
		.running (),
		.expired (win_expired),
		.elapsed (win_elapsed)
	);

	swa_timer u_gnd_timer (
		.clock   (clock),
		.reset_n (reset_n),
		.load    (gnd_load),
		.stop    (gnd_stop),
		.limit   (LIM_GND),
		.running (gnd_running),
		.expired (gnd_expired),
		.elapsed (gnd_elapsed)
	);

	// ****************************************************************
	// Activation state machine
	// ****************************************************************
	swa_pkg::swa_state_t          state;
	swa_pkg::swa_state_t          next_state;
	logic [swa_pkg::CTRL_W-1:0]   ctrl;
	logic [swa_pkg::IRQ_W-1:0]    evt;
	logic next_uplink, next_sync_req, next_ready_req, next_cap, next_app_select;
	logic last_ready, next_last_ready, subsequent, next_subsequent;
	logic once_activated, next_once, full_power, next_full_power;
	logic linked, next_linked, grounded, next_grounded, act_done, gnd_cond;

	// Grounding applies only while the terminal has never shown link support
	assign gnd_cond = !tie_sync && !ctrl[swa_pkg::CTRL_SWP_KNOWN] && !once_activated
		&& !grounded && (state == swa_pkg::ST_DEACT || state == swa_pkg::ST_INHIBIT);
	assign gnd_load = gnd_cond && !gnd_running && !gnd_expired;
	assign gnd_stop = !gnd_cond;

	always_comb begin
		next_state      = state;
		next_uplink     = uplink_current_signal;
		next_sync_req   = 1'b0;
		next_ready_req  = 1'b0;
		next_cap        = capability_info_field;
		next_app_select = 1'b0;
		next_last_ready = last_ready;
		next_subsequent = subsequent;
		next_once       = once_activated;
		next_full_power = full_power;
		next_linked     = linked;
		next_grounded   = grounded;
		win_load        = 1'b0;
		win_stop        = 1'b0;
		win_limit       = LIM_PU;
		evt             = '0;
		act_done        = 1'b0;
		case (state)
			swa_pkg::ST_DEACT: begin
				if (s1_rise && ctrl[swa_pkg::CTRL_ENABLE] && !grounded) begin // RULE1
					next_state      = swa_pkg::ST_WAIT_RESUME;
					next_subsequent = once_activated;
					win_load        = 1'b1;
					win_limit       = once_activated ? LIM_IDLE : LIM_PU; // RULE4 RULE8
				end
			end
			swa_pkg::ST_WAIT_RESUME: begin
				// Timer compares every cycle, so hold this window's limit while it runs
				win_limit = subsequent ? LIM_IDLE : LIM_PU; // RULE4 RULE8
				// Resume early when the stack is ready, forced at the window edge
				if (stack_ready || win_expired) begin // RULE4 RULE8
					next_state  = swa_pkg::ST_RESUMED;
					next_uplink = 1'b1;
					win_load    = 1'b1;
					win_limit   = LIM_DET; // RULE6
				end
			end
			swa_pkg::ST_RESUMED: begin
				win_limit = LIM_DET; // RULE6
				if (s1_rise) begin
					next_state      = swa_pkg::ST_SEND_SYNC;
					win_stop        = 1'b1;
					next_linked     = 1'b1;
					next_sync_req   = 1'b1;
					next_cap        = !subsequent; // RULE2
					next_last_ready = 1'b0;
				end else if (win_expired) begin // RULE7
					next_state  = swa_pkg::ST_INHIBIT;
					next_uplink = 1'b0;
					evt[swa_pkg::IRQ_TIMEOUT] = 1'b1;
				end
			end
			swa_pkg::ST_SEND_SYNC: begin
				if (tx_done) begin
					next_state = swa_pkg::ST_WAIT_PM;
					act_done   = subsequent;
				end
			end
			swa_pkg::ST_WAIT_PM: begin
				// A corrupted frame gets no answer at all
				if (rx_pm_done && rx_pm_ok) begin // RULE15
					next_full_power = rx_full_power;
					next_state      = swa_pkg::ST_SEND_REPLY;
					win_load        = 1'b1;
					win_limit       = LIM_PM; // RULE5
					if (frame_repeat_bit && !last_ready) begin
						next_sync_req = 1'b1;
					end else begin
						next_ready_req  = 1'b1;
						next_last_ready = 1'b1;
					end
				end
			end
			swa_pkg::ST_SEND_REPLY: begin
				win_limit = LIM_PM; // RULE5
				if (tx_done) begin
					win_stop   = 1'b1;
					next_state = last_ready ? swa_pkg::ST_ACTIVE : swa_pkg::ST_WAIT_PM;
					act_done   = last_ready && !subsequent;
				end else if (win_expired) begin // RULE5
					evt[swa_pkg::IRQ_LATE] = 1'b1;
					next_state = swa_pkg::ST_WAIT_PM;
				end
			end
			swa_pkg::ST_ACTIVE: begin
				next_state = swa_pkg::ST_ACTIVE;
			end
			swa_pkg::ST_INHIBIT: begin
				// Link attempts are ignored until software reports link support
				if (ctrl[swa_pkg::CTRL_SWP_KNOWN]) // RULE7
					next_state = swa_pkg::ST_DEACT;
			end
			default: next_state = swa_pkg::ST_DEACT;
		endcase
		if (act_done) begin
			next_once = 1'b1;
			evt[swa_pkg::IRQ_ACTIVATED] = 1'b1;
			if (ctrl[swa_pkg::CTRL_CONTACT_ACTIVE]) begin // RULE12
				next_app_select = 1'b1;
				evt[swa_pkg::IRQ_APP_SELECT] = 1'b1;
			end
		end
		// Deactivation overrides any activation step in progress
		if (link_idle && state != swa_pkg::ST_DEACT && state != swa_pkg::ST_INHIBIT) begin
			next_state     = swa_pkg::ST_DEACT;
			next_uplink    = 1'b0;
			next_linked    = 1'b0;
			next_sync_req  = 1'b0;
			next_ready_req = 1'b0;
			win_load       = 1'b0;
			win_stop       = 1'b1;
		end
		if (gnd_expired && gnd_cond) begin // RULE13
			next_grounded = 1'b1;
			evt[swa_pkg::IRQ_GROUNDED] = 1'b1;
		end else if (tie_sync || ctrl[swa_pkg::CTRL_SWP_KNOWN]) begin
			next_grounded = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state                 <= swa_pkg::ST_DEACT;
			uplink_current_signal <= 1'b0;
			tx_sync_req           <= 1'b0;
			tx_ready_req          <= 1'b0;
			capability_info_field <= 1'b1;
			app_select_pulse      <= 1'b0;
			last_ready            <= 1'b0;
			subsequent            <= 1'b0;
			once_activated        <= 1'b0;
			full_power            <= 1'b0;
			linked                <= 1'b0;
			grounded              <= 1'b0;
			wire_gnd_oe_n         <= 1'b1;
			wire_gnd_out          <= 1'b0;
		end else begin
			state                 <= next_state;
			uplink_current_signal <= next_uplink;
			tx_sync_req           <= next_sync_req;
			tx_ready_req          <= next_ready_req;
			capability_info_field <= next_cap;
			app_select_pulse      <= next_app_select;
			last_ready            <= next_last_ready;
			subsequent            <= next_subsequent;
			once_activated        <= next_once;
			full_power            <= next_full_power;
			linked                <= next_linked;
			grounded              <= next_grounded;
			wire_gnd_oe_n         <= !next_grounded; // RULE13
			wire_gnd_out          <= 1'b0;
		end
	end

	// ****************************************************************
	// Registers and interrupt
	// ****************************************************************
	logic [swa_pkg::CTRL_W-1:0] next_ctrl;
	logic [swa_pkg::IRQ_W-1:0]  irq_status;
	logic [swa_pkg::IRQ_W-1:0]  next_irq_status;
	logic [swa_pkg::IRQ_W-1:0]  irq_mask;
	logic [swa_pkg::IRQ_W-1:0]  next_irq_mask;
	logic [swa_pkg::IRQ_W-1:0]  irq_clear;
	logic [swa_pkg::STAT_W-1:0] stat;
	logic [swa_pkg::DATA_W-1:0] next_rd_data;

	// Decode writes and reads; a new event wins over a clear in the same cycle
	always_comb begin
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		irq_clear     = '0;
		next_rd_data  = '0;
		stat          = '0;
		stat[swa_pkg::STAT_LINKED]     = linked;
		stat[swa_pkg::STAT_INHIBIT]    = (state == swa_pkg::ST_INHIBIT);
		stat[swa_pkg::STAT_FULL_POWER] = full_power;
		stat[swa_pkg::STAT_SUBSEQUENT] = subsequent;
		stat[swa_pkg::STAT_GROUNDED]   = grounded;
		if (wr_strobe) begin
			if (addr == swa_pkg::REG_CTRL)
				next_ctrl = wr_data[swa_pkg::CTRL_W-1:0];
			else if (addr == swa_pkg::REG_IRQ_STATUS)
				irq_clear = wr_data[swa_pkg::IRQ_W-1:0];
			else if (addr == swa_pkg::REG_IRQ_MASK)
				next_irq_mask = wr_data[swa_pkg::IRQ_W-1:0];
		end
		if (rd_strobe) begin
			if (addr == swa_pkg::REG_CTRL)
				next_rd_data = {{(swa_pkg::DATA_W-swa_pkg::CTRL_W){1'b0}}, ctrl};
			else if (addr == swa_pkg::REG_STATUS)
				next_rd_data = {{(swa_pkg::DATA_W-swa_pkg::STAT_W){1'b0}}, stat};
			else if (addr == swa_pkg::REG_IRQ_STATUS)
				next_rd_data = {{(swa_pkg::DATA_W-swa_pkg::IRQ_W){1'b0}}, irq_status};
			else if (addr == swa_pkg::REG_IRQ_MASK)
				next_rd_data = {{(swa_pkg::DATA_W-swa_pkg::IRQ_W){1'b0}}, irq_mask};
		end
		next_irq_status = (irq_status & ~irq_clear) | evt;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl       <= swa_pkg::CTRL_RESET;
			irq_status <= '0;
			irq_mask   <= swa_pkg::IRQ_MASK_RESET;
			rd_data    <= '0;
			irq        <= 1'b0;
		end else begin
			ctrl       <= next_ctrl;
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			rd_data    <= next_rd_data;
			irq        <= |(next_irq_status & next_irq_mask);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	rerun_start_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE1
		(state == swa_pkg::ST_DEACT && s1_rise && ctrl[swa_pkg::CTRL_ENABLE] && !grounded)
		|=> state == swa_pkg::ST_WAIT_RESUME)
		else $error("downlink rise did not restart activation");
	no_cap_info_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE2
		(tx_sync_req && subsequent) |-> !capability_info_field)
		else $error("capability field sent in subsequent activation");
	resume_power_up_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE4
		(state == swa_pkg::ST_WAIT_RESUME && !subsequent) |-> win_elapsed <= LIM_PU)
		else $error("power-up resume window overrun");
	resume_idle_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE8
		(state == swa_pkg::ST_WAIT_RESUME && subsequent) |-> win_elapsed <= LIM_IDLE)
		else $error("resume window from idle overrun");
	pm_window_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE5
		(state == swa_pkg::ST_SEND_REPLY) |-> win_elapsed <= LIM_PM)
		else $error("power-mode reply window overrun");
	detect_timeout_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE6
		(state == swa_pkg::ST_RESUMED) |-> (uplink_current_signal && win_elapsed <= LIM_DET))
		else $error("activation detect timeout overrun");
	inhibit_quiet_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE7
		(state == swa_pkg::ST_INHIBIT && !ctrl[swa_pkg::CTRL_SWP_KNOWN])
		|=> (state == swa_pkg::ST_INHIBIT && !uplink_current_signal && !tx_sync_req))
		else $error("inhibited card responded to the link");
	repeat_reply_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE15
		(state == swa_pkg::ST_WAIT_PM && rx_pm_done && rx_pm_ok && frame_repeat_bit
		&& !last_ready && !link_idle) |=> (tx_sync_req && !tx_ready_req))
		else $error("repeat request not answered with sync frame");
	ready_reply_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE15
		(state == swa_pkg::ST_WAIT_PM && rx_pm_done && rx_pm_ok && !frame_repeat_bit
		&& !link_idle) |=> (tx_ready_req && !tx_sync_req))
		else $error("power-mode frame not answered with ready frame");
	app_select_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE12
		(act_done && ctrl[swa_pkg::CTRL_CONTACT_ACTIVE]) |=> (app_select_pulse
		&& irq_status[swa_pkg::IRQ_APP_SELECT]))
		else $error("application select not signalled");
	ground_time_a: assert property (@(posedge clock) disable iff (!reset_n) // RULE13
		gnd_cond |-> (gnd_elapsed <= LIM_GND && LIM_GND < LIM_GMAX && wire_gnd_oe_n))
		else $error("wire grounding late");

endmodule

// [shared/swa_pkg.sv]
// ****************************************************************
// Timing, register map and state encoding
// ****************************************************************
package swa_pkg;

	// Base clock, 100 MHz
	localparam int CLOCK_PERIOD_NS       = 10;
	localparam int CYC_PER_US            = 1000 / CLOCK_PERIOD_NS;
	// Fraction of each maximum actually used except the ground maximum, leaves room for clock tolerance
	localparam int MARGIN_PCT            = 80;

	// Times in their own units
	localparam int RESUME_PU_MAX_US      = 700;
	localparam int RESUME_IDLE_MAX_US    = 500;
	localparam int PM_RESPONSE_MAX_US    = 2000;
	localparam int DETECT_TIMEOUT_MAX_MS = 100;
	localparam int GROUND_MAX_S          = 2;
	localparam int GROUND_SETTLE_US      = 1000;
	localparam int DEACT_LOW_US          = 20;

	// Cycle counts derived from the times
	localparam int RESUME_PU_CYC   = RESUME_PU_MAX_US * CYC_PER_US / 100 * MARGIN_PCT;
	localparam int RESUME_IDLE_CYC = RESUME_IDLE_MAX_US * CYC_PER_US / 100 * MARGIN_PCT;
	localparam int PM_RESPONSE_CYC = PM_RESPONSE_MAX_US * CYC_PER_US / 100 * MARGIN_PCT;
	localparam int DETECT_CYC      = DETECT_TIMEOUT_MAX_MS * 1000 * CYC_PER_US / 100 * MARGIN_PCT;
	localparam int GROUND_MAX_CYC  = GROUND_MAX_S * 1000000 * CYC_PER_US;
	localparam int GROUND_SETTLE_CYC = GROUND_SETTLE_US * CYC_PER_US;
	localparam int DEACT_LOW_CYC   = DEACT_LOW_US * CYC_PER_US;

	// Counter widths
	localparam int TIMER_W = 28;
	localparam int DEACT_W = 12;
	localparam logic [TIMER_W-1:0] TIMER_ONE = 28'h0000001;
	localparam logic [DEACT_W-1:0] DEACT_ONE = 12'h001;
	localparam logic [DEACT_W-1:0] DEACT_LIM = 12'h7D0;

	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h0C;

	// Control fields
	localparam int CTRL_W              = 3;
	localparam int CTRL_ENABLE         = 0;
	localparam int CTRL_SWP_KNOWN      = 1;
	localparam int CTRL_CONTACT_ACTIVE = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h1;

	// Status fields
	localparam int STAT_W          = 5;
	localparam int STAT_LINKED     = 0;
	localparam int STAT_INHIBIT    = 1;
	localparam int STAT_FULL_POWER = 2;
	localparam int STAT_SUBSEQUENT = 3;
	localparam int STAT_GROUNDED   = 4;

	// Interrupt fields
	localparam int IRQ_W          = 5;
	localparam int IRQ_ACTIVATED  = 0;
	localparam int IRQ_TIMEOUT    = 1;
	localparam int IRQ_APP_SELECT = 2;
	localparam int IRQ_GROUNDED   = 3;
	localparam int IRQ_LATE       = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

	typedef enum logic [2:0] {
		ST_DEACT,
		ST_WAIT_RESUME,
		ST_RESUMED,
		ST_SEND_SYNC,
		ST_WAIT_PM,
		ST_SEND_REPLY,
		ST_ACTIVE,
		ST_INHIBIT
	} swa_state_t;

endpackage

// [hdl/swa_timer.sv]
`timescale 1ns/10ps
// ****************************************************************
// Window timer on the internal clock
// ****************************************************************
module swa_timer (
	// Clock and reset
	input  wire logic                       clock,
	input  wire logic                       reset_n,
	// Control
	input  wire logic                       load,
	input  wire logic                       stop,
	input  wire logic [swa_pkg::TIMER_W-1:0] limit,
	// State
	output logic                            running,
	output logic                            expired,
	output logic [swa_pkg::TIMER_W-1:0]     elapsed
);

	logic                        next_running;
	logic                        next_expired;
	logic [swa_pkg::TIMER_W-1:0] next_elapsed;

	// Count up from load, one expiry pulse when the limit is reached
	always_comb begin
		next_running = running;
		next_expired = 1'b0;
		next_elapsed = elapsed;
		if (load) begin
			next_running = 1'b1;
			next_elapsed = '0;
		end else if (stop) begin
			next_running = 1'b0;
		end else if (running) begin
			if (elapsed == limit - swa_pkg::TIMER_ONE) begin // RULE17
				next_running = 1'b0;
				next_expired = 1'b1;
			end
			next_elapsed = elapsed + swa_pkg::TIMER_ONE;
		end
	end

	// Register the timer state
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			running <= 1'b0;
			expired <= 1'b0;
			elapsed <= '0;
		end else begin
			running <= next_running;
			expired <= next_expired;
			elapsed <= next_elapsed;
		end
	end

endmodule

// [verification/swa_fe_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Front-end model driving the downlink
// ****************************************************************
module swa_fe_model (
	// Clock
	input  wire logic clock,
	// Commands from the bench
	input  wire logic link_on,
	input  wire logic bit_req,
	// Downlink to the card
	output logic      downlink_voltage_signal
);
	logic [2:0] low_cnt;

	// Each bit is a low gap then a rising edge; the gap outlasts the card's sync chain
	always_ff @(posedge clock) begin
		if (!link_on) begin
			downlink_voltage_signal <= 1'b0;
			low_cnt                 <= 3'h0;
		end else if (bit_req) begin
			downlink_voltage_signal <= 1'b0;
			low_cnt                 <= 3'h4;
		end else if (low_cnt != 3'h0) begin
			low_cnt <= low_cnt - 3'h1;
		end else begin
			downlink_voltage_signal <= 1'b1;
		end
	end
endmodule

// [verification/test_swa_activation_ctrl.sv]
`timescale 1ns/10ps
module test_swa_activation_ctrl;
	logic clock, reset_n, wr_strobe, rd_strobe, irq, s1, tied, stack_ready, tx_done, pm_done;
	logic pm_ok, rep, full, sync_req, ready_req, cap, app, up, gnd_out, gnd_oe_n, link_on, bit_req;
	logic [7:0]  addr;
	logic [31:0] wr_data, rd_data;
	int          miscompares, n_tests;

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	swa_fe_model FE (.clock(clock), .link_on(link_on), .bit_req(bit_req),
		.downlink_voltage_signal(s1));
	// Short windows keep the run brief
	swa_activation_ctrl #(.RESUME_PU_CYC(40), .RESUME_IDLE_CYC(30), .PM_RESPONSE_CYC(50),
		.DETECT_CYC(100), .GROUND_SETTLE_CYC(60)) DUT (
		.clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .irq(irq),
		.downlink_voltage_signal(s1), .wire_tied_supply(tied), .uplink_current_signal(up),
		.wire_gnd_out(gnd_out), .wire_gnd_oe_n(gnd_oe_n), .stack_ready(stack_ready),
		.tx_done(tx_done), .rx_pm_done(pm_done), .rx_pm_ok(pm_ok), .frame_repeat_bit(rep),
		.rx_full_power(full), .tx_sync_req(sync_req), .tx_ready_req(ready_req),
		.capability_info_field(cap), .app_select_pulse(app));

	task give_verdict();
		if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock) {addr, wr_data, wr_strobe} <= {a, d, 1'b1};
		@(posedge clock) wr_strobe <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock) {addr, rd_strobe} <= {a, 1'b1};
		@(posedge clock) rd_strobe <= 1'b0;
		@(negedge clock) chk(rd_data, exp);
	endtask
	// Waits on one output by index; running out of cycles ends the run
	task wait_hi(input int w, input int lim);
		int i;
		logic [5:0] watch;
		for (i = 0; i < lim; i++) begin
			@(negedge clock);
			watch = {~gnd_oe_n, app, ~up, ready_req, sync_req, up};
			if (watch[w] === 1'b1) break;
		end
		if (i == lim) begin
			miscompares++;
			give_verdict();
		end
	endtask
	task pulse(input logic is_pm, input logic r);
		@(posedge clock) {pm_done, tx_done, rep} <= {is_pm, !is_pm, r};
		@(posedge clock) {pm_done, tx_done} <= 2'b00;
	endtask
	task link_bit();
		@(posedge clock) bit_req <= 1'b1;
		@(posedge clock) bit_req <= 1'b0;
	endtask

	initial begin
		{reset_n, addr, wr_data, wr_strobe, rd_strobe, tied, stack_ready} = '0;
		{tx_done, pm_done, rep, link_on, bit_req} = '0;
		{pm_ok, full} = 2'b11;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		rd(swa_pkg::REG_CTRL, 32'h00000001);
		rd(swa_pkg::REG_IRQ_MASK, 32'h00000000);
		rd(8'h10, 32'h00000000);
		wr(swa_pkg::REG_IRQ_MASK, 32'h0000001F);
		wr(swa_pkg::REG_CTRL, 32'h00000005);
		// First activation with a repeat request then a ready reply
		link_on <= 1'b1;
		wait_hi(0, 48);
		link_bit();
		wait_hi(1, 10);
		chk(cap, 1'b1);
		pulse(1'b0, 1'b0);
		pm_ok <= 1'b0;
		pulse(1'b1, 1'b0);
		@(negedge clock) chk({sync_req, ready_req}, 2'b00);
		@(posedge clock) pm_ok <= 1'b1;
		pulse(1'b1, 1'b1);
		wait_hi(1, 5);
		pulse(1'b0, 1'b0);
		pulse(1'b1, 1'b0);
		wait_hi(2, 5);
		pulse(1'b0, 1'b0);
		wait_hi(4, 5);
		rd(swa_pkg::REG_IRQ_STATUS, 32'h00000005);
		rd(swa_pkg::REG_STATUS, 32'h00000005);
		wr(swa_pkg::REG_IRQ_STATUS, 32'h0000001F);
		@(negedge clock) chk(irq, 1'b0);
		// Deactivate, then a subsequent activation
		link_on <= 1'b0;
		wait_hi(3, 2100);
		repeat (20) @(posedge clock);
		{link_on, stack_ready} <= 2'b11;
		wait_hi(0, 8);
		link_bit();
		wait_hi(1, 10);
		chk(cap, 1'b0);
		pulse(1'b0, 1'b0);
		rd(swa_pkg::REG_IRQ_STATUS, 32'h00000005);
		wr(swa_pkg::REG_IRQ_STATUS, 32'h0000001F);
		// No activated state seen: timeout then the link is ignored
		{link_on, stack_ready} <= 2'b00;
		wait_hi(3, 2100);
		repeat (20) @(posedge clock);
		link_on <= 1'b1;
		wait_hi(0, 38);
		wait_hi(3, 110);
		rd(swa_pkg::REG_IRQ_STATUS, 32'h00000002);
		link_bit();
		repeat (10) @(negedge clock);
		chk({sync_req, up}, 2'b00);
		// Fresh reset, isolated wire, no link support: card grounds it
		@(posedge clock);
		link_on <= 1'b0;
		reset_n <= 1'b0;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		wait_hi(5, 80);
		chk(gnd_out, 1'b0);
		give_verdict();
	end
endmodule
